// ===== verilog/usbp_pkg.sv
// Shared constants and types of the USB port enable and connect-status block
package usbp_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int USBP_AW   = 8;
    localparam int USBP_DW   = 32;
    localparam int USBP_SW   = USBP_DW / 8;
    localparam int USBP_DS_W = 8;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [USBP_AW-1:0] USBP_OFS_PORTSC = 8'h00;
    localparam logic [USBP_AW-1:0] USBP_OFS_STAT   = 8'h04;
    localparam logic [USBP_AW-1:0] USBP_OFS_MASK   = 8'h08;

    // Port status/control fields
    localparam int USBP_PRESENT_BIT = 0;
    localparam int USBP_CHG_BIT     = 1;
    localparam int USBP_EN_BIT      = 2;
    localparam int USBP_PWR_BIT     = 12;
    localparam int USBP_CTRL_LANE   = 0;

    // Interrupt events, same layout in status and mask
    localparam int USBP_EV_CONN = 0;
    localparam int USBP_EV_DIS  = 1;
    localparam int USBP_EV_N    = 2;

    // ------------------------------------------------------------------
    // Reset values and responses
    // ------------------------------------------------------------------
    localparam logic [USBP_EV_N-1:0] USBP_EV_RST   = 2'h0;
    localparam logic [1:0]           USBP_RESP_OK  = 2'h0;
    localparam logic [1:0]           USBP_RESP_DEC = 2'h3;

    typedef enum logic [1:0] {
        PS_DISABLED,
        PS_RESETTING,
        PS_ENABLED
    } usbp_port_e;
endpackage

// ===== verilog/usbp_reg_if.sv
// Register access carrier between the bus slave and the port logic
interface usbp_reg_if;
    import usbp_pkg::*;
    logic                 wr_en;
    logic [USBP_AW-1:0]   wr_addr;
    logic [USBP_DW-1:0]   wr_data;
    logic [USBP_SW-1:0]   wr_strb;
    logic                 wr_ok;
    logic [USBP_AW-1:0]   rd_addr;
    logic [USBP_DW-1:0]   rd_data;
    logic                 rd_ok;

    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input  wr_ok, rd_data, rd_ok);
    modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface

// ===== verilog/usbp_sync.sv
// Two-stage synchroniser for pin inputs
module usbp_sync #(
    parameter int W = 1
) (
    // Clock and control
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import usbp_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } usbp_sync_s;

    usbp_sync_s st_q;
    usbp_sync_s st_d;

    // First stage feeds only the second
    always_comb
    begin
        st_d = st_q;
        if (clk_en)
        begin
            st_d.s1 = d;
            st_d.s2 = st_q.s1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign q = st_q.s2;
endmodule

// ===== verilog/usbp_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register accesses
module usbp_axil_slave (
    // Clock and control
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic                         clk_en,
    // Write channels
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [usbp_pkg::USBP_AW-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    input  wire logic [usbp_pkg::USBP_DW-1:0] s_axi_wdata,
    input  wire logic [usbp_pkg::USBP_SW-1:0] s_axi_wstrb,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    output logic      [1:0]                   s_axi_bresp,
    // Read channels
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    input  wire logic [usbp_pkg::USBP_AW-1:0] s_axi_araddr,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic      [usbp_pkg::USBP_DW-1:0] s_axi_rdata,
    output logic      [1:0]                   s_axi_rresp,
    // Register side
    usbp_reg_if.bus                           rif
);
    import usbp_pkg::*;

    typedef struct packed {
        logic               awready;
        logic               wready;
        logic               aw_have;
        logic               w_have;
        logic [USBP_AW-1:0] awaddr;
        logic [USBP_DW-1:0] wdata;
        logic [USBP_SW-1:0] wstrb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               ar_have;
        logic [USBP_AW-1:0] araddr;
        logic               rvalid;
        logic [USBP_DW-1:0] rdata;
        logic [1:0]         rresp;
    } usbp_axi_s;

    usbp_axi_s st_q;
    usbp_axi_s st_d;

    // Address and data are held separately, so either may arrive first
    always_comb
    begin
        st_d = st_q;
        if (clk_en)
        begin
            if (st_q.awready && s_axi_awvalid)
            begin
                st_d.awready = 1'b0;
                st_d.aw_have = 1'b1;
                st_d.awaddr  = s_axi_awaddr;
            end
            if (st_q.wready && s_axi_wvalid)
            begin
                st_d.wready = 1'b0;
                st_d.w_have = 1'b1;
                st_d.wdata  = s_axi_wdata;
                st_d.wstrb  = s_axi_wstrb;
            end
            if (rif.wr_en)
            begin
                st_d.bvalid = 1'b1;
                st_d.bresp  = rif.wr_ok ? USBP_RESP_OK : USBP_RESP_DEC;
            end
            if (st_q.bvalid && s_axi_bready)
            begin
                st_d.bvalid  = 1'b0;
                st_d.aw_have = 1'b0;
                st_d.w_have  = 1'b0;
                st_d.awready = 1'b1;
                st_d.wready  = 1'b1;
            end
            if (st_q.arready && s_axi_arvalid)
            begin
                st_d.arready = 1'b0;
                st_d.ar_have = 1'b1;
                st_d.araddr  = s_axi_araddr;
            end
            if (st_q.ar_have && !st_q.rvalid)
            begin
                st_d.rvalid = 1'b1;
                st_d.rdata  = rif.rd_data;
                st_d.rresp  = rif.rd_ok ? USBP_RESP_OK : USBP_RESP_DEC;
            end
            if (st_q.rvalid && s_axi_rready)
            begin
                st_d.rvalid  = 1'b0;
                st_d.ar_have = 1'b0;
                st_d.arready = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q         <= '0;
            st_q.awready <= 1'b1;
            st_q.wready  <= 1'b1;
            st_q.arready <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    assign rif.wr_en   = clk_en && st_q.aw_have && st_q.w_have && !st_q.bvalid;
    assign rif.wr_addr = st_q.awaddr;
    assign rif.wr_data = st_q.wdata;
    assign rif.wr_strb = st_q.wstrb;
    assign rif.rd_addr = st_q.araddr;

    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
endmodule

// ===== verilog/usbp_port_top.sv
// Port enable and connect-status logic of one root-hub port, with register access
// Behaviour
// - Software writing one to the enable bit never enables the port.
// - Enable is set only when reset finishes with a high-speed device detected.
// - Disconnect, fault or a software zero write clears the enable bit.
// - Enable bit follows the real port state change, possibly after a delay.
// - Disabled port blocks downstream data; reset signalling still passes.
// - Enable bit resets to zero; one means enabled.
// - Enable, change flag and presence read zero while port power is off.
// - Every presence change while port power is on sets the sticky change flag; it resets to zero.
// - Writing one clears the change flag; writing zero leaves it alone.
// - Presence bit reads one while a device is attached; resets to zero.
// - Presence bit shows the live state, not a latched event.
module usbp_port_top #(
    parameter int DS_W = usbp_pkg::USBP_DS_W
) (
    // Clock, reset, enable
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic                         clk_en,
    // AXI4-Lite write
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [usbp_pkg::USBP_AW-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    input  wire logic [usbp_pkg::USBP_DW-1:0] s_axi_wdata,
    input  wire logic [usbp_pkg::USBP_SW-1:0] s_axi_wstrb,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    output logic      [1:0]                   s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    input  wire logic [usbp_pkg::USBP_AW-1:0] s_axi_araddr,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic      [usbp_pkg::USBP_DW-1:0] s_axi_rdata,
    output logic      [1:0]                   s_axi_rresp,
    // Port pin and port logic
    input  wire logic                         dev_attach_pin,
    input  wire logic                         port_power,
    input  wire logic                         port_reset_req,
    input  wire logic                         port_reset_done,
    input  wire logic                         port_reset_hs,
    input  wire logic                         port_fault,
    // Downstream data path
    input  wire logic                         ds_valid_in,
    input  wire logic [DS_W-1:0]              ds_data_in,
    output logic                              ds_valid_out,
    output logic      [DS_W-1:0]              ds_data_out,
    output logic                              reset_drive_out,
    // Status
    output logic                              port_enabled,
    output logic                              irq
);
    import usbp_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        usbp_port_e           state;
        logic                 port_enabled;
        logic                 device_present;
        logic                 connect_change_flag;
        logic [USBP_EV_N-1:0] sts;
        logic [USBP_EV_N-1:0] mask;
        logic                 irq;
        logic                 ds_valid;
        logic [DS_W-1:0]      ds_data;
        logic                 reset_drive;
    } usbp_main_s;

    usbp_main_s st_q;
    usbp_main_s st_d;

    usbp_reg_if rif ();

    logic attach_sync;
    logic portsc_wr;
    logic stat_wr;
    logic mask_wr;
    logic cut;
    logic sw_disable;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    usbp_sync #(
        .W (1)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .d       (dev_attach_pin),
        .q       (attach_sync)
    );

    usbp_axil_slave u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .clk_en        (clk_en),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .rif           (rif.bus)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Only the low byte lane holds writable bits
    assign portsc_wr = rif.wr_en && rif.wr_strb[USBP_CTRL_LANE]
                       && (rif.wr_addr == USBP_OFS_PORTSC);
    assign stat_wr   = rif.wr_en && rif.wr_strb[USBP_CTRL_LANE]
                       && (rif.wr_addr == USBP_OFS_STAT);
    assign mask_wr   = rif.wr_en && rif.wr_strb[USBP_CTRL_LANE]
                       && (rif.wr_addr == USBP_OFS_MASK);
    assign rif.wr_ok = (rif.wr_addr == USBP_OFS_PORTSC) || (rif.wr_addr == USBP_OFS_STAT)
                       || (rif.wr_addr == USBP_OFS_MASK);

    assign cut        = !port_power || !attach_sync;
    assign sw_disable = portsc_wr && !rif.wr_data[USBP_EN_BIT];

    // Readback is gated by power directly, no lag behind the flops
    always_comb
    begin
        rif.rd_data = '0;
        rif.rd_ok   = 1'b1;
        case (rif.rd_addr)
            USBP_OFS_PORTSC:
            begin
                rif.rd_data[USBP_PRESENT_BIT] = port_power && st_q.device_present;
                rif.rd_data[USBP_CHG_BIT]     = port_power && st_q.connect_change_flag;
                rif.rd_data[USBP_EN_BIT]      = port_power && st_q.port_enabled;
                rif.rd_data[USBP_PWR_BIT]     = port_power;
            end
            USBP_OFS_STAT:
                rif.rd_data[USBP_EV_N-1:0] = st_q.sts;
            USBP_OFS_MASK:
                rif.rd_data[USBP_EV_N-1:0] = st_q.mask;
            default:
                rif.rd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        if (clk_en)
        begin
            // Live presence, forced low without power
            st_d.device_present = port_power && attach_sync;

            if (!port_power)
                st_d.connect_change_flag = 1'b0;
            else
            begin
                if (portsc_wr && rif.wr_data[USBP_CHG_BIT])
                    st_d.connect_change_flag = 1'b0;
                // Set after clear so a change in the clearing cycle survives
                if (st_d.device_present != st_q.device_present)
                    st_d.connect_change_flag = 1'b1;
            end

            if (stat_wr)
                st_d.sts = st_q.sts & ~rif.wr_data[USBP_EV_N-1:0];
            if (mask_wr)
                st_d.mask = rif.wr_data[USBP_EV_N-1:0];
            if (st_d.device_present != st_q.device_present)
                st_d.sts[USBP_EV_CONN] = 1'b1;

            // A one written to enable has no path here
            case (st_q.state)
                PS_DISABLED:
                begin
                    if (port_reset_req && !cut)
                        st_d.state = PS_RESETTING;
                end
                PS_RESETTING:
                begin
                    if (cut)
                        st_d.state = PS_DISABLED;
                    else if (port_reset_done)
                        st_d.state = port_reset_hs ? PS_ENABLED : PS_DISABLED;
                end
                PS_ENABLED:
                begin
                    if (cut || port_fault)
                    begin
                        st_d.state            = PS_DISABLED;
                        st_d.sts[USBP_EV_DIS] = 1'b1;
                    end
                    else if (sw_disable)
                        st_d.state = PS_DISABLED;
                    else if (port_reset_req)
                        st_d.state = PS_RESETTING;
                end
                default:
                    st_d.state = PS_DISABLED;
            endcase
            st_d.port_enabled = (st_d.state == PS_ENABLED);

            st_d.irq = |(st_d.sts & st_d.mask);

            // Data gated by the enable; reset signalling is never gated
            st_d.ds_valid    = st_d.port_enabled && ds_valid_in;
            st_d.ds_data     = st_d.port_enabled ? ds_data_in : '0;
            st_d.reset_drive = port_reset_req;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q       <= '0;
            st_q.state <= PS_DISABLED;
            st_q.sts   <= USBP_EV_RST;
            st_q.mask  <= USBP_EV_RST;
        end
        else
            st_q <= st_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ds_valid_out    = st_q.ds_valid;
    assign ds_data_out     = st_q.ds_data;
    assign reset_drive_out = st_q.reset_drive;
    assign port_enabled    = st_q.port_enabled;
    assign irq             = st_q.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Frozen cycles would break next-cycle checks, so they are excluded
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !clk_en);

    property p_sw_no_enable;
        portsc_wr && rif.wr_data[USBP_EN_BIT] && st_q.state == PS_DISABLED
            |=> !st_q.port_enabled;
    endproperty
    a_sw_no_enable: assert property (p_sw_no_enable)
        else $error("software write enabled the port");

    property p_enable_needs_hs;
        $rose(st_q.port_enabled)
            |-> $past(port_reset_done && port_reset_hs && st_q.state == PS_RESETTING);
    endproperty
    a_enable_needs_hs: assert property (p_enable_needs_hs)
        else $error("port enabled without high-speed reset completion");

    property p_fault_clears;
        st_q.port_enabled && (port_fault || cut) |=> !st_q.port_enabled ##0 st_q.sts[USBP_EV_DIS];
    endproperty
    a_fault_clears: assert property (p_fault_clears)
        else $error("fault or disconnect did not disable the port");

    property p_sw_disable;
        st_q.port_enabled && sw_disable |=> !st_q.port_enabled;
    endproperty
    a_sw_disable: assert property (p_sw_disable)
        else $error("software zero write did not disable the port");

    property p_enable_cause;
        $fell(st_q.port_enabled) |-> $past(cut || port_fault || sw_disable || port_reset_req);
    endproperty
    a_enable_cause: assert property (p_enable_cause)
        else $error("enable dropped without a port state change");

    property p_gate;
        !port_enabled |-> !ds_valid_out && ds_data_out == '0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("data passed a disabled port");

    property p_reset_pass;
        port_reset_req |=> reset_drive_out;
    endproperty
    a_reset_pass: assert property (p_reset_pass)
        else $error("reset signalling was blocked");

    property p_power_off_read;
        !port_power && rif.rd_addr == USBP_OFS_PORTSC
            |-> rif.rd_data[USBP_EN_BIT:USBP_PRESENT_BIT] == '0;
    endproperty
    a_power_off_read: assert property (p_power_off_read)
        else $error("port fields nonzero with power off");

    property p_chg_set;
        port_power && attach_sync != st_q.device_present |=> st_q.connect_change_flag;
    endproperty
    a_chg_set: assert property (p_chg_set)
        else $error("presence change did not set the change flag");

    property p_chg_w1c;
        port_power && portsc_wr && rif.wr_data[USBP_CHG_BIT]
            && attach_sync == st_q.device_present |=> !st_q.connect_change_flag;
    endproperty
    a_chg_w1c: assert property (p_chg_w1c)
        else $error("write one did not clear the change flag");

    property p_chg_hold;
        port_power && st_q.connect_change_flag
            && !(portsc_wr && rif.wr_data[USBP_CHG_BIT]) |=> st_q.connect_change_flag;
    endproperty
    a_chg_hold: assert property (p_chg_hold)
        else $error("change flag dropped without a one write");

    property p_present_live;
        port_power ##1 port_power |-> st_q.device_present == $past(attach_sync);
    endproperty
    a_present_live: assert property (p_present_live)
        else $error("presence bit does not follow the port");

    property p_same_cycle;
        $changed(st_q.device_present) && $past(port_power) |-> st_q.connect_change_flag;
    endproperty
    a_same_cycle: assert property (p_same_cycle)
        else $error("change flag lagged the presence update");

    c_enable: cover property ($rose(st_q.port_enabled));
    c_disconnect: cover property (st_q.port_enabled ##1 !st_q.device_present);
    c_irq: cover property ($rose(irq));
endmodule

// ===== verif/usbp_dev_model.sv
// Behavioural attached device and reset-sequence answer on the downstream port
module usbp_dev_model (
    // Clock and test control
    input  wire logic aclk,
    input  wire logic plug,
    input  wire logic hs_cap,
    // Port side
    input  wire logic reset_drive,
    output logic      attach_pin,
    output logic      done,
    output logic      hs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_q;
    // Speed line only meaningful with done; inverted otherwise
    always @(posedge aclk)
    begin
        rd_q <= reset_drive;
        attach_pin <= plug;
        done <= rd_q && !reset_drive;
        hs <= (rd_q && !reset_drive) ? hs_cap : !hs_cap;
    end
endmodule

// ===== verif/usbp_port_enable_connect_tb_top.sv
// Register-level bench of the port enable and connect-status block
module usb_host_port_enable_connect_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import usbp_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, en, pin, done, hs, dvo, rdo;
    logic [7:0] awaddr = 0, araddr = 0, dso;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic pwr = 0, rreq = 0, flt = 0, dvi = 0, plug = 1, hsc = 0;
    int errors = 0, comparisons = 0, cyc = 0;
    initial
    begin
        forever #20 aclk = ~aclk;
    end
    usbp_port_top i_usbp_port_top (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .dev_attach_pin(pin), .port_power(pwr), .port_reset_req(rreq), .port_reset_done(done),
        .port_reset_hs(hs), .port_fault(flt), .ds_valid_in(dvi), .ds_data_in(8'h5a),
        .ds_valid_out(dvo), .ds_data_out(dso), .reset_drive_out(rdo), .port_enabled(en),
        .irq(irq));
    usbp_dev_model i_usbp_dev_model (.aclk(aclk), .plug(plug), .hs_cap(hsc),
        .reset_drive(rdo), .attach_pin(pin), .done(done), .hs(hs));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("%0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk({30'h0, bresp}, {30'h0, USBP_RESP_OK});
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, rsp});
    endtask
    task port_rst(input logic s);
        hsc  <= s;
        rreq <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({31'h0, rdo}, 32'h0000_0001);
        rreq <= 0;
        repeat (5) @(posedge aclk);
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            errors++;
            end_sim;
        end
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(USBP_OFS_PORTSC, 32'h0000_0000, USBP_RESP_OK);
        wr(USBP_OFS_MASK, 32'h0000_0003);
        repeat (6) @(posedge aclk);
        rd(USBP_OFS_PORTSC, 32'h0000_0000, USBP_RESP_OK);
        pwr <= 1;
        repeat (6) @(posedge aclk);
        rd(USBP_OFS_PORTSC, 32'h0000_1003, USBP_RESP_OK);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(USBP_OFS_STAT, 32'h0000_0001);
        rd(USBP_OFS_STAT, 32'h0000_0000, USBP_RESP_OK);
        wr(USBP_OFS_PORTSC, 32'h0000_0004);
        rd(USBP_OFS_PORTSC, 32'h0000_1003, USBP_RESP_OK);
        wr(USBP_OFS_PORTSC, 32'h0000_0002);
        rd(USBP_OFS_PORTSC, 32'h0000_1001, USBP_RESP_OK);
        $display("test registers done");
        port_rst(0);
        chk({31'h0, en}, 32'h0000_0000);
        port_rst(1);
        rd(USBP_OFS_PORTSC, 32'h0000_1005, USBP_RESP_OK);
        dvi <= 1;
        repeat (2) @(posedge aclk);
        chk({23'h0, dvo, dso}, 32'h0000_015a);
        wr(USBP_OFS_PORTSC, 32'h0000_0000);
        chk({30'h0, en, dvo}, 32'h0000_0000);
        $display("test enable done");
        port_rst(1);
        flt <= 1;
        @(posedge aclk);
        flt <= 0;
        repeat (2) @(posedge aclk);
        chk({30'h0, en, irq}, 32'h0000_0001);
        rd(USBP_OFS_STAT, 32'h0000_0002, USBP_RESP_OK);
        plug <= 0;
        repeat (6) @(posedge aclk);
        rd(USBP_OFS_PORTSC, 32'h0000_1002, USBP_RESP_OK);
        rd(8'h0c, 32'h0000_0000, USBP_RESP_DEC);
        pwr <= 1'b0;
        rd(USBP_OFS_PORTSC, 32'h0000_0000, USBP_RESP_OK);
        $display("test fault and detach done");
        end_sim;
    end
endmodule
